// >>> hdl/ssr_status.sv
`timescale 1ns/1ps
// Function
// - options query returns four capability tokens
// - reset zeroes current, voltage, output off
// - reset clears latched overvoltage/overcurrent fault
// - enable mask takes 0..255, bit 6 ignored
// - masked status bits ORed into bit 6
// - serial poll clears RQS; MSS follows sources
// - status byte bit layout fixed
// - status byte query reads, clears nothing
// - status bits clear only via sources
// - serial poll returns RQS in bit 6
// - enable mask query returns stored value
// - enabled event bits set summary bit 5
// - unrecognized command sets command error bit
// - event register read clears it
// - operation-complete reply waits for idle
// - self-test answers 0 pass, nonzero fail
// - error class selects event bits 5..2
// - clear-status empties queues, keeps masks
module ssr_status #(
   parameter int OQ_DEPTH = 32,
   parameter int OQ_AW    = 5
) (
   input  wire logic              clk_sys,    // System clock
   input  wire logic              reset,      // Sync reset
   input  wire logic              ce,         // Clock enable
   input  ssr_pkg::ssr_req_s      req,        // Command request
   output logic                   req_ready,  // Command accepted
   input  ssr_pkg::ssr_src_s      src,        // Status sources
   input  wire logic              fault_in,   // OV/OC fault event
   output logic                   fault,      // Latched fault
   input  wire logic              spoll,      // Serial poll strobe
   output logic [7:0]             spoll_byte, // Poll response
   output logic                   srq,        // Service request line
   input  wire logic              rd_pop,     // Host reads a byte
   output logic [7:0]             rd_data,    // Output queue head
   output logic                   rd_valid,   // Byte available
   output logic                   err_q_clr,  // Empty error queue
   output logic [7:0]             status_summary_byte, // Live status
   output logic [7:0]             service_request_mask, // Enable mask
   output ssr_pkg::ssr_lvl_s      lvl         // Programmed levels
);
   import ssr_pkg::*;

   typedef enum logic [3:0] {
      SSR_ST_IDLE = 4'b0001,   // Waiting for a command
      SSR_ST_EMIT = 4'b0010,   // Sending a reply string
      SSR_ST_OPCW = 4'b0100,   // Waiting for operations to finish
      SSR_ST_DONE = 4'b1000    // One-cycle completion
   } ssr_st_e;

   typedef struct packed {
      ssr_st_e     fsm;
      logic [7:0]  srm;        // Service request enable
      logic [7:0]  ese;        // Event status enable
      logic        rqs;        // Request-for-service latch
      logic        mss_prev;   // MSS of last cycle
      logic        fault;      // Latched OV/OC
      logic        opc_arm;    // *OPC pending
      logic        rst_clr;    // Pending clear (clear-status)
      ssr_lvl_s    lvl;        // Programmed levels
      logic [8*OPT_LEN-1:0] msg;  // Reply shift register
      logic [4:0]  msg_left;   // Bytes left in reply
      logic [7:0]  spoll_byte; // Registered poll byte
   } ssr_core_s;

   ssr_core_s  st_q, st_d;        // Block state
   logic [7:0] evt_set;           // Event set pulses
   logic       evt_clr;           // Event register clear
   logic [7:0] evt;               // Event register value
   logic       q_push, q_full;    // Queue write side
   logic [7:0] q_data;            // Byte to queue
   logic       q_flush;           // Queue empty request
   logic       mav;               // Message available
   logic       esb;               // Event summary
   logic       mss;               // Master summary
   logic [7:0] ssb_raw;           // Status byte without bit 6
   logic       cmd_take;          // Command taken this cycle

   // Event class decode
   function automatic logic [7:0] err_bits(input logic v,
                                           input logic [3:0] c);
      logic [7:0] b;
      b = BYTE_ZERO;
      if (v) begin
         unique case (c)
            ERR_CLS_CMD: b[ESR_CME] = 1'b1;
            ERR_CLS_EXE: b[ESR_EXE] = 1'b1;
            ERR_CLS_DEV: b[ESR_DDE] = 1'b1;
            ERR_CLS_QRY: b[ESR_QUE] = 1'b1;
            default:     b = BYTE_ZERO;
         endcase
      end
      return b;
   endfunction

   // Byte to decimal ASCII and a line feed, left-aligned into the reply buffer
   function automatic logic [8*OPT_LEN-1:0] num_str(input logic [7:0] v);
      logic [8*OPT_LEN-1:0] s;
      logic [7:0] h, t, o;
      h = v / 8'd100;
      t = (v % 8'd100) / 8'd10;
      o = v % 8'd10;
      s = '0;
      s[8*OPT_LEN-1 -: 8]  = ASCII_ZERO + h;
      s[8*OPT_LEN-9 -: 8]  = ASCII_ZERO + t;
      s[8*OPT_LEN-17 -: 8] = ASCII_ZERO + o;
      s[8*OPT_LEN-25 -: 8] = 8'h0A;
      return s;
   endfunction

   // Status byte assembly
   always_comb begin
      ssb_raw           = BYTE_ZERO;
      ssb_raw[SSB_OPER] = src.oper_sum;
      ssb_raw[SSB_ESB]  = esb;
      ssb_raw[SSB_MAV]  = mav;
      ssb_raw[SSB_QUES] = src.ques_sum;
      ssb_raw[SSB_ERRQ] = src.err_valid;
   end

   assign esb  = |(evt & st_q.ese);
   assign mss  = |(ssb_raw & st_q.srm & SRM_WR_MASK);
   // Live value; no read path clears anything here
   assign status_summary_byte  = ssb_raw | ({7'h00, mss} << SSB_RQS);
   assign service_request_mask = st_q.srm;
   assign srq        = st_q.rqs;
   assign spoll_byte = st_q.spoll_byte;
   assign fault      = st_q.fault;
   assign lvl        = st_q.lvl;
   assign cmd_take   = req.valid && req_ready;
   assign req_ready  = (st_q.fsm == SSR_ST_IDLE);

   // Event set sources
   always_comb begin
      evt_set = err_bits(src.err_valid, src.err_class);
      if (cmd_take && req.cmd == SSR_CMD_BAD)
         evt_set[ESR_CME] = 1'b1;
      if (st_q.opc_arm && !src.busy)
         evt_set[ESR_OPC] = 1'b1;
   end

   assign evt_clr = cmd_take && (req.cmd == SSR_CMD_ESR_RD ||
                                 req.cmd == SSR_CMD_CLS);
   assign q_flush = cmd_take && req.cmd == SSR_CMD_CLS;
   assign err_q_clr = q_flush;

   // Reply byte emitter
   assign q_push = (st_q.fsm == SSR_ST_EMIT) && !q_full;
   assign q_data = st_q.msg[8*OPT_LEN-1 -: 8];

   // Next-state logic
   always_comb begin
      st_d = st_q;
      st_d.mss_prev = mss;
      // RQS rises with MSS; a poll hands it out and drops it
      if (spoll) begin
         st_d.spoll_byte = ssb_raw | ({7'h00, st_q.rqs} << SSB_RQS);
         st_d.rqs = 1'b0;
      end
      if (mss && !st_q.mss_prev) st_d.rqs = 1'b1;
      if (!mss) st_d.rqs = 1'b0;
      if (fault_in) st_d.fault = 1'b1;
      if (st_q.opc_arm && !src.busy) st_d.opc_arm = 1'b0;
      unique case (st_q.fsm)
         SSR_ST_IDLE: begin
            if (cmd_take) begin
               unique case (req.cmd)
                  SSR_CMD_SRM_WR: st_d.srm = req.arg & SRM_WR_MASK;
                  SSR_CMD_ESE_WR: st_d.ese = req.arg;
                  SSR_CMD_OPC:    st_d.opc_arm = 1'b1;
                  SSR_CMD_RST: begin
                     st_d.lvl.curr   = LEVEL_ZERO;
                     st_d.lvl.volt   = LEVEL_ZERO;
                     st_d.lvl.out_on = 1'b0;
                     st_d.fault      = 1'b0;
                     st_d.fsm        = SSR_ST_DONE;
                  end
                  SSR_CMD_OPT_Q: begin
                     st_d.msg      = OPT_STRING;
                     st_d.msg_left = 5'(OPT_LEN);
                     st_d.fsm      = SSR_ST_EMIT;
                  end
                  SSR_CMD_OPC_Q: st_d.fsm = SSR_ST_OPCW;
                  SSR_CMD_SRM_RD, SSR_CMD_ESE_RD, SSR_CMD_ESR_RD,
                  SSR_CMD_SSB_RD, SSR_CMD_TST_Q: begin
                     unique case (req.cmd)
                        SSR_CMD_SRM_RD: st_d.msg = num_str(st_q.srm);
                        SSR_CMD_ESE_RD: st_d.msg = num_str(st_q.ese);
                        SSR_CMD_ESR_RD: st_d.msg = num_str(evt);
                        SSR_CMD_SSB_RD:
                           st_d.msg = num_str(status_summary_byte);
                        default:
                           st_d.msg = num_str(src.tst_fail ?
                                      src.tst_addr : BYTE_ZERO);
                     endcase
                     st_d.msg_left = 5'd4;
                     st_d.fsm      = SSR_ST_EMIT;
                  end
                  default: st_d.fsm = st_q.fsm;
               endcase
            end
         end
         SSR_ST_OPCW: begin
            if (!src.busy) begin
               st_d.msg      = {ASCII_ONE, 8'h0A, {(8*OPT_LEN-16){1'b0}}};
               st_d.msg_left = 5'd2;
               st_d.fsm      = SSR_ST_EMIT;
            end
         end
         SSR_ST_EMIT: begin
            if (q_push) begin
               st_d.msg      = st_q.msg << 8;
               st_d.msg_left = st_q.msg_left - 5'd1;
               if (st_q.msg_left == 5'd1) st_d.fsm = SSR_ST_IDLE;
            end
         end
         SSR_ST_DONE: st_d.fsm = SSR_ST_IDLE;
      endcase
   end

   // State register; masks zero at power-on
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q     <= '0;
         st_q.fsm <= SSR_ST_IDLE;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // Event register
   ssr_evt u_evt (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .ce       (ce),
      .set_bits (evt_set),
      .clr      (evt_clr),
      .evt_q    (evt)
   );

   // Output queue; MAV is its non-empty flag
   ssr_outq #(.DEPTH(OQ_DEPTH), .AW(OQ_AW)) u_oq (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .ce        (ce),
      .flush     (q_flush),
      .push      (q_push),
      .push_data (q_data),
      .full      (q_full),
      .pop       (rd_pop),
      .pop_data  (rd_data),
      .not_empty (mav)
   );

   assign rd_valid = mav;
endmodule // ssr_status

// >>> common/ssr_pkg.sv
package ssr_pkg;

   // Status byte bit positions
   localparam int SSB_OPER = 7;
   localparam int SSB_RQS  = 6;
   localparam int SSB_ESB  = 5;
   localparam int SSB_MAV  = 4;
   localparam int SSB_QUES = 3;
   localparam int SSB_ERRQ = 2;

   // Event status bit positions
   localparam int ESR_PON = 7;
   localparam int ESR_CME = 5;
   localparam int ESR_EXE = 4;
   localparam int ESR_DDE = 3;
   localparam int ESR_QUE = 2;
   localparam int ESR_OPC = 0;

   // Reset and fixed values
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [7:0]  SRM_WR_MASK  = 8'hBF;
   localparam logic [7:0]  ASCII_ONE    = 8'h31;
   localparam logic [7:0]  ASCII_ZERO   = 8'h30;
   localparam logic [7:0]  ASCII_COMMA  = 8'h2C;
   localparam logic [15:0] LEVEL_ZERO   = 16'h0000;

   // Error classes (hundreds digit of the error code)
   localparam logic [3:0] ERR_CLS_CMD = 4'h1;
   localparam logic [3:0] ERR_CLS_EXE = 4'h2;
   localparam logic [3:0] ERR_CLS_DEV = 4'h3;
   localparam logic [3:0] ERR_CLS_QRY = 4'h4;

   // Options reply: capability tokens separated by commas
   localparam int OPT_LEN = 17;
   localparam logic [8*OPT_LEN-1:0] OPT_STRING = {
      8'h52, 8'h49, 8'h31, 8'h2C,          // clear_response_option_token
      8'h43, 8'h48, 8'h4E, 8'h2C,          // multichannel_option_token
      8'h44, 8'h53, 8'h30, 8'h2C,          // display_no_text_token
      8'h43, 8'h49, 8'h49, 8'h4C,          // legacy_language_token
      8'h0A};                              // Terminator

   // Host command codes
   typedef enum logic [3:0] {
      SSR_CMD_NONE   = 4'h0,
      SSR_CMD_CLS    = 4'h1,
      SSR_CMD_ESE_WR = 4'h2,
      SSR_CMD_ESE_RD = 4'h3,
      SSR_CMD_ESR_RD = 4'h4,
      SSR_CMD_OPC    = 4'h5,
      SSR_CMD_OPC_Q  = 4'h6,
      SSR_CMD_OPT_Q  = 4'h7,
      SSR_CMD_RST    = 4'h8,
      SSR_CMD_SRM_WR = 4'h9,
      SSR_CMD_SRM_RD = 4'hA,
      SSR_CMD_SSB_RD = 4'hB,
      SSR_CMD_TST_Q  = 4'hC,
      SSR_CMD_BAD    = 4'hF
   } ssr_cmd_e;

   // Command request carrier
   typedef struct packed {
      logic       valid;
      ssr_cmd_e   cmd;
      logic [7:0] arg;
   } ssr_req_s;

   // Status sources from the rest of the instrument
   typedef struct packed {
      logic oper_sum;
      logic ques_sum;
      logic busy;
      logic err_valid;
      logic [3:0] err_class;
      logic tst_fail;
      logic [7:0] tst_addr;
   } ssr_src_s;

   // Output level programming
   typedef struct packed {
      logic [15:0] curr;
      logic [15:0] volt;
      logic        out_on;
   } ssr_lvl_s;

endpackage

// >>> hdl/ssr_outq.sv
`timescale 1ns/1ps
// Response byte queue; message-available tracks non-empty state
module ssr_outq #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   input  wire logic       clk_sys,    // System clock
   input  wire logic       reset,      // Sync reset
   input  wire logic       ce,         // Clock enable
   input  wire logic       flush,      // Empty the queue
   input  wire logic       push,       // Write a byte
   input  wire logic [7:0] push_data,  // Byte written
   output logic            full,       // No room
   input  wire logic       pop,        // Host takes a byte
   output logic [7:0]      pop_data,   // Head byte
   output logic            not_empty   // Unread byte present
);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic [7:0]    head;
   } ssr_oq_s;

   ssr_oq_s    st_q, st_d;              // Pointer state
   logic [7:0] mem [DEPTH];             // Byte storage
   logic       do_push, do_pop;         // Qualified strobes

   assign full      = (st_q.cnt == (AW+1)'(DEPTH));
   assign not_empty = (st_q.cnt != '0);
   assign do_push   = push && !full && !flush;
   assign do_pop    = pop && not_empty && !flush;
   assign pop_data  = mem[st_q.rp];

   // Pointer and count update
   always_comb begin
      st_d = st_q;
      if (flush) begin
         st_d = '0;
      end else begin
         if (do_push) st_d.wp = st_q.wp + 1'b1;
         if (do_pop)  st_d.rp = st_q.rp + 1'b1;
         if (do_push && !do_pop) st_d.cnt = st_q.cnt + 1'b1;
         if (do_pop && !do_push) st_d.cnt = st_q.cnt - 1'b1;
      end
      st_d.head = '0;
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) st_q <= '0;
      else if (ce) st_q <= st_d;
   end

   // Storage write
   always_ff @(posedge clk_sys) begin
      if (ce && do_push) mem[st_q.wp] <= push_data;
   end
endmodule // ssr_outq

// >>> hdl/ssr_evt.sv
`timescale 1ns/1ps
// Standard event register with read-clear, set wins over clear
module ssr_evt (
   input  wire logic       clk_sys,   // System clock
   input  wire logic       reset,     // Sync reset
   input  wire logic       ce,        // Clock enable
   input  wire logic [7:0] set_bits,  // Event set pulses
   input  wire logic       clr,       // Clear (read or clear-status)
   output logic [7:0]      evt_q      // Event register
);
   import ssr_pkg::*;

   typedef struct packed {
      logic [7:0] evt;
   } ssr_ev_s;

   ssr_ev_s st_q, st_d;   // Register state

   // Clear first, then new events land
   always_comb begin
      st_d = st_q;
      if (clr) st_d.evt = BYTE_ZERO;
      st_d.evt = st_d.evt | set_bits;
   end

   // Power-on event flagged at reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q.evt          <= BYTE_ZERO;
         st_q.evt[ESR_PON] <= 1'b1;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign evt_q = st_q.evt;
endmodule // ssr_evt

// >>> sim/ssr_host_model.sv
`timescale 1ns/1ps
// Host side: sends one command at a time, pops reply bytes
module ssr_host_model (
   input  wire logic        clk_sys,   // System clock
   input  wire logic        slow,      // Pop on some cycles only
   output ssr_pkg::ssr_req_s req,      // Command request
   input  wire logic        req_ready, // Command taken
   output logic             rd_pop,    // Take head byte
   input  wire logic [7:0]  rd_data,   // Head byte
   input  wire logic        rd_valid,  // Byte waiting
   output logic             rsp_stb,   // Whole reply seen
   output logic [135:0]     rsp_line   // Reply, last byte lowest
);
   import ssr_pkg::*;
   logic [135:0] line_q; // Reply bytes so far
   initial begin
      req = '0;
      rd_pop = 0;
      rsp_stb = 0;
      line_q = '0;
   end
   // Hold the request until taken; released request shows junk arg
   task send(input ssr_cmd_e c, input logic [7:0] a);
      @(negedge clk_sys);
      req = '{1'b1, c, a};
      do @(posedge clk_sys); while (req_ready !== 1'b1);
      @(negedge clk_sys);
      req = '{1'b0, SSR_CMD_NONE, ~a};
   endtask
   // Pop whenever a byte waits, now and then when slow
   always @(negedge clk_sys)
      rd_pop <= rd_valid && (!slow || $urandom_range(1) == 1);
   // Gather bytes; a line feed closes the reply
   always @(posedge clk_sys) begin
      rsp_stb <= rd_pop && rd_data == 8'h0A;
      if (rd_pop) begin
         line_q <= (rd_data == 8'h0A) ? '0 : {line_q[127:0], rd_data};
         rsp_line <= {line_q[127:0], rd_data};
      end
   end
endmodule // ssr_host_model

// >>> sim/ssr_status_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the status byte and request logic
module ssr_status_asserts (
   input wire logic        clk_sys,              // System clock
   input wire logic        reset,                // Sync reset
   input wire logic        ce,                   // Clock enable
   input ssr_pkg::ssr_req_s req,                 // Command request
   input wire logic        req_ready,            // Command taken
   input wire logic        fault,                // Latched fault
   input wire logic        spoll,                // Poll strobe
   input wire logic [7:0]  spoll_byte,           // Poll reply
   input wire logic        srq,                  // Request line
   input wire logic        rd_pop,               // Byte read
   input wire logic        rd_valid,             // Message waiting
   input wire logic        err_q_clr,            // Clear pulse
   input wire logic [7:0]  status_summary_byte,  // Live status
   input wire logic [7:0]  service_request_mask, // Enable mask
   input ssr_pkg::ssr_lvl_s lvl                  // Levels
);
   import ssr_pkg::*;
   logic tk; // Request taken this edge
   assign tk = req.valid && req_ready && ce;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   chk_mask_bit6: assert property (service_request_mask[6] == 1'b0)
      else $error("mask bit 6 set");
   chk_mask_write: assert property (tk && req.cmd == SSR_CMD_SRM_WR
      |=> service_request_mask == ($past(req.arg) & 8'hBF))
      else $error("mask write wrong");
   chk_mss_sum: assert property (status_summary_byte[6] ==
      |(status_summary_byte & service_request_mask & 8'hBF))
      else $error("summary bit wrong");
   chk_unused_zero: assert property (status_summary_byte[1:0] == 2'b00)
      else $error("unused bits set");
   chk_poll_byte: assert property (spoll |=> spoll_byte ==
      {$past(status_summary_byte[7]), $past(srq),
       $past(status_summary_byte[5:0])})
      else $error("poll byte wrong");
   chk_poll_clears: assert property (spoll |=> !srq)
      else $error("request kept after poll");
   chk_rqs_needs_mss: assert property (srq |-> $past(status_summary_byte[6]))
      else $error("request without summary");
   chk_rst_level: assert property (tk && req.cmd == SSR_CMD_RST
      |-> ##[1:3] (lvl == '0 && !fault))
      else $error("reset left level or fault");
   chk_cls_mask: assert property (tk && req.cmd == SSR_CMD_CLS
      |=> $stable(service_request_mask))
      else $error("clear changed mask");
   chk_mav_fall: assert property ($fell(rd_valid)
      |-> $past(rd_pop) || $past(err_q_clr))
      else $error("message flag dropped unread");

   cov_poll: cover property (spoll && srq);
   cov_rst: cover property (tk && req.cmd == SSR_CMD_RST);
   cov_cls: cover property (tk && req.cmd == SSR_CMD_CLS);
   cov_mav: cover property ($fell(rd_valid));
endmodule // ssr_status_asserts

bind ssr_status ssr_status_asserts u_chk (.clk_sys(clk_sys),
   .reset(reset), .ce(ce), .req(req), .req_ready(req_ready),
   .fault(fault), .spoll(spoll), .spoll_byte(spoll_byte), .srq(srq),
   .rd_pop(rd_pop), .rd_valid(rd_valid), .err_q_clr(err_q_clr),
   .status_summary_byte(status_summary_byte),
   .service_request_mask(service_request_mask), .lvl(lvl));

// >>> sim/test_status_byte_service_request.sv
`timescale 1ns/1ps
// Bench: host sends commands, watcher checks each reply in order
module test_status_byte_service_request;
   import ssr_pkg::*;
   logic         clk_sys = 0;  // 10 MHz clock
   logic         reset = 1;    // Sync reset
   logic         fault_in = 0; // Fault event
   logic         spoll = 0;    // Poll strobe
   logic         slow = 0;     // Slow host reads
   logic         rd_pop, rd_valid, srq, fault, rsp_stb, req_ready;
   logic [7:0]   rd_data, spoll_byte, ssb, srm;
   logic [135:0] rsp_line;     // Reply seen by host
   logic [135:0] expq[$];      // Replies still owed
   ssr_req_s     req;          // Command request
   ssr_src_s     src = '0;     // Status sources
   ssr_lvl_s     lvl;          // Levels
   int           errors = 0;
   int           checks = 0;

   always #50 clk_sys = ~clk_sys;

   ssr_status DUT (.clk_sys(clk_sys), .reset(reset), .ce(1'b1),
      .req(req), .req_ready(req_ready), .src(src), .fault_in(fault_in),
      .fault(fault), .spoll(spoll), .spoll_byte(spoll_byte), .srq(srq),
      .rd_pop(rd_pop), .rd_data(rd_data), .rd_valid(rd_valid),
      .err_q_clr(), .status_summary_byte(ssb),
      .service_request_mask(srm), .lvl(lvl));
   ssr_host_model u_host (.clk_sys(clk_sys), .slow(slow), .req(req),
      .req_ready(req_ready), .rd_pop(rd_pop), .rd_data(rd_data),
      .rd_valid(rd_valid), .rsp_stb(rsp_stb), .rsp_line(rsp_line));

   // Compare and count
   task chk(string nm, logic [135:0] seen, logic [135:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Three decimal digits and a line feed
   function logic [135:0] num(int n);
      return {8'h30 + 8'(n / 100), 8'h30 + 8'(n / 10 % 10),
              8'h30 + 8'(n % 10), 8'h0A};
   endfunction
   // Wait, bounded, until every owed reply came
   task drain;
      for (int i = 0; i < 400 && expq.size() > 0; i++) @(negedge clk_sys);
      chk("owed", expq.size(), 0);
   endtask
   // Query with its expected reply
   task q(ssr_cmd_e c, logic [135:0] e);
      expq.push_back(e);
      u_host.send(c, 8'h00);
      drain();
   endtask
   // Watcher: oldest note against each whole reply
   always @(negedge clk_sys) begin
      if (rsp_stb) chk("reply", rsp_line, expq.size() ? expq.pop_front() : '1);
   end
   // Counts and verdict
   task final_report;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (30000) @(posedge clk_sys);
      errors++;
      final_report();
   end
   // Main sequence
   initial begin
      logic [7:0] v;
      void'($urandom(32'hD9565670));
      repeat (12) @(negedge clk_sys);
      reset = 0;
      chk("srm", srm, 0);
      chk("lvl", lvl, 0);
      q(SSR_CMD_ESE_RD, num(0));
      q(SSR_CMD_SSB_RD, num(0));
      $display("done reset");
      for (int i = 0; i < 4; i++) begin
         v = i ? 8'($urandom) : 8'hFF;
         u_host.send(SSR_CMD_SRM_WR, v);
         q(SSR_CMD_SRM_RD, num(v & 8'hBF));
      end
      $display("done mask");
      // Event summary raises request; poll drops only the request
      u_host.send(SSR_CMD_SRM_WR, 8'h20);
      u_host.send(SSR_CMD_ESE_WR, 8'h3C);
      u_host.send(SSR_CMD_BAD, 8'h00);
      q(SSR_CMD_SSB_RD, num(96));
      q(SSR_CMD_SSB_RD, num(96));
      chk("srq", srq, 1);
      spoll = 1;
      @(negedge clk_sys);
      spoll = 0;
      chk("poll", spoll_byte, 8'h60);
      chk("rqs", srq, 0);
      chk("mss", ssb[6], 1);
      q(SSR_CMD_ESR_RD, num(160));
      q(SSR_CMD_ESR_RD, num(0));
      q(SSR_CMD_SSB_RD, num(0));
      $display("done poll");
      for (int c = 1; c < 5; c++) begin
         src.err_valid = 1;
         src.err_class = 4'(c);
         @(negedge clk_sys);
         src.err_valid = 0;
         q(SSR_CMD_ESR_RD, num(1 << (6 - c)));
      end
      src.oper_sum = 1;
      src.ques_sum = 1;
      q(SSR_CMD_SSB_RD, num(136));
      u_host.send(SSR_CMD_SRM_WR, 8'h88);
      q(SSR_CMD_SSB_RD, num(200));
      src = '0;
      q(SSR_CMD_SSB_RD, num(0));
      u_host.send(SSR_CMD_BAD, 8'h00);
      u_host.send(SSR_CMD_CLS, 8'h00);
      q(SSR_CMD_ESR_RD, num(0));
      q(SSR_CMD_SRM_RD, num(136));
      // Completion command marks event bit 0 once idle
      u_host.send(SSR_CMD_OPC, 8'h00);
      q(SSR_CMD_ESR_RD, num(1));
      $display("done sources");
      fault_in = 1;
      @(negedge clk_sys);
      fault_in = 0;
      chk("fault", fault, 1);
      u_host.send(SSR_CMD_RST, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk("fault", fault, 0);
      chk("lvl", lvl, 0);
      slow = 1;
      q(SSR_CMD_OPT_Q, OPT_STRING);
      slow = 0;
      // Completion reply held back while busy
      src.busy = 1;
      expq.push_back({8'h31, 8'h0A});
      u_host.send(SSR_CMD_OPC_Q, 8'h00);
      repeat (30) @(negedge clk_sys);
      chk("early", rd_valid, 0);
      src.busy = 0;
      drain();
      chk("mav", rd_valid, 0);
      q(SSR_CMD_TST_Q, num(0));
      v = 8'($urandom_range(255, 1));
      src.tst_fail = 1;
      src.tst_addr = v;
      q(SSR_CMD_TST_Q, num(v));
      $display("done commands");
      final_report();
   end
endmodule // test_status_byte_service_request
